// ---- cmb_pkg.sv ----
// Shared constants and types of the CAN message-slot block
package cmb_pkg;
  // Slot geometry
  localparam int SLOTS  = 16;
  localparam int WORDS  = 8;
  localparam int FLAG_W = 19;
  localparam int ADDR_W = 10;

  // Byte addresses of the register map
  localparam logic [9:0] ADDR_REGS   = 10'h200;
  localparam logic [9:0] ADDR_FLAGS  = 10'h200;
  localparam logic [9:0] ADDR_IMASK  = 10'h204;
  localparam logic [9:0] ADDR_SHMASK = 10'h208;
  localparam logic [9:0] ADDR_M14    = 10'h20c;
  localparam logic [9:0] ADDR_M15    = 10'h210;
  localparam logic [9:0] ADDR_TIMER  = 10'h214;
  localparam logic [9:0] ADDR_BITDIV = 10'h218;

  // Word index inside a slot
  localparam int W_CTRL  = 0;
  localparam int W_IDHI  = 1;
  localparam int W_IDLO  = 2;
  localparam int W_DATA0 = 3;

  // Control/status word fields
  localparam int CODE_LSB  = 4;
  localparam int STAMP_LSB = 8;

  // Arbitration field bits, in identifier words and as 32-bit pair
  localparam int          HI_IDE = 3;
  localparam int          HI_SRR = 4;
  localparam int          LO_RTR = 0;
  localparam logic [31:0] ID_ALL = 32'hffff_ffff;
  localparam logic [31:0] ID_STD = 32'hffff_0000;
  localparam logic [31:0] ID_IDE = 32'h0008_0000;
  localparam logic [31:0] ID_SRR = 32'h0010_0000;
  localparam logic [31:0] ID_RTR = 32'h0000_0001;
  localparam logic [31:0] MASK_RST = 32'hffff_ffff;

  // Event bits above the slot flags
  localparam int EV_BUSOFF = 16;
  localparam int EV_ERR    = 17;
  localparam int EV_WAKE   = 18;

  // Timing
  localparam int CLK_NS      = 5;
  localparam int MIN_BIT_NS  = 1000;
  localparam int MIN_BIT_CYC = (MIN_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] BIT_LIM_MIN = 16'(MIN_BIT_CYC - 1);

  // Bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;

  typedef enum logic [3:0] {
    RX_IDLE      = 4'h0,
    RX_EMPTY     = 4'h4,
    RX_FULL      = 4'h2,
    RX_OVERRUN   = 4'h6,
    TX_IDLE      = 4'h8,
    TX_SEND      = 4'hc,
    TX_RESP      = 4'ha,
    TX_RESP_BUSY = 4'he
  } cmb_code_e;

  typedef enum logic [1:0] {
    TS_IDLE  = 2'b00,
    TS_OFFER = 2'b01,
    TS_BUSY  = 2'b10
  } cmb_txst_e;
endpackage

// ---- cmb_match.sv ----
// Acceptance filter for one message slot
`timescale 1ns/100ps
module cmb_match
  import cmb_pkg::*;
(
  // Slot contents
  input  wire logic [3:0]  code,
  input  wire logic [15:0] slotHi,
  input  wire logic [15:0] slotLo,
  input  wire logic [31:0] mask,
  // Frame held in a serial buffer
  input  wire logic [15:0] frameHi,
  input  wire logic [15:0] frameLo,
  // Results
  output logic             rxHit,
  output logic             rrHit
);
  logic        frameIde;
  logic        frameRtr;
  logic        rxCode;
  logic [31:0] exact;
  logic [31:0] diff;

  assign frameIde = frameHi[HI_IDE];
  assign frameRtr = frameIde ? frameLo[LO_RTR] : frameHi[HI_SRR];
  // Standard slots keep the time stamp in the low word, so it is never compared
  assign exact = (frameIde ? ID_ALL : ID_STD) & ~(ID_SRR | ID_RTR);
  assign diff  = {slotHi, slotLo} ^ {frameHi, frameLo};
  assign rxCode = code == RX_EMPTY || code == RX_FULL || code == RX_OVERRUN;
  // Zero mask bits are don't-care; format bit always compared
  // Remote frames bypass the mask
  assign rxHit = rxCode
    && ((diff & (frameRtr ? exact : (exact & (mask | ID_IDE)))) == 32'h0);
  assign rrHit = code == TX_RESP && frameRtr && ((diff & exact) == 32'h0);
endmodule

// ---- cmb_message_buffers.sv ----
// Message slots, filtering, serial buffers, timer and AXI4-Lite registers of a CAN node
`timescale 1ns/100ps
module cmb_message_buffers
  import cmb_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Received frames from the protocol engine
  input  wire logic               rxSof,
  input  wire logic               rxValid,
  output logic                    rxReady,
  input  wire logic [15:0]        rxIdHi,
  input  wire logic [15:0]        rxIdLo,
  input  wire logic [3:0]         rxLen,
  input  wire logic [63:0]        rxData,
  // Frames to the protocol engine
  output logic                    txValid,
  input  wire logic               txReady,
  output logic [15:0]             txIdHi,
  output logic [15:0]             txIdLo,
  output logic [3:0]              txLen,
  output logic [63:0]             txData,
  input  wire logic               txDone,
  input  wire logic               txLost,
  // Controller events and outputs
  input  wire logic               busOffEvt,
  input  wire logic               errEvt,
  input  wire logic               wakeEvt,
  output logic                    bitTick,
  output logic                    intReq
);
  logic [15:0]       mem [SLOTS*WORDS];
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] intMask;
  logic [31:0]       shMask;
  logic [31:0]       m14;
  logic [31:0]       m15;
  logic [15:0]       bitDiv;
  logic [15:0]       divCnt;
  logic [15:0]       timer;
  logic [ADDR_W-1:0] wAddr;
  logic [31:0]       wDat;
  logic [3:0]        wStb;
  logic              doWrite;
  logic              doRead;
  logic              wSlot;
  logic [31:0]       rdNext;
  logic              rdErr;
  logic              lockOn;
  logic [3:0]        lockSlot;
  // Serial buffers
  logic [1:0]        sbValid;
  logic              sbWr;
  logic              sbRd;
  logic [15:0]       sbHi [2];
  logic [15:0]       sbLo [2];
  logic [3:0]        sbLen [2];
  logic [63:0]       sbData [2];
  logic [15:0]       sbStamp [2];
  logic [15:0]       rxStamp;
  logic [1:0]        next_sbValid;
  logic              push;
  logic              pop;
  // Matching
  logic [SLOTS-1:0]  rxHit;
  logic [SLOTS-1:0]  rrHit;
  logic [3:0]        selIdx;
  logic              selRx;
  logic              selRr;
  logic              stall;
  logic              doStore;
  logic              doRemote;
  // Transmit
  cmb_txst_e         txSt;
  logic [3:0]        txSlot;
  logic [15:0]       txStamp;
  logic              txCand;
  logic [3:0]        txBest;
  logic              txFinish;
  logic [FLAG_W-1:0] flagSet;
  logic [FLAG_W-1:0] flagClr;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  // AXI4-Lite slave: one write and one read in flight
  assign doWrite = !awready && !wready && !bvalid;
  assign doRead  = arvalid && arready;
  assign wSlot   = wAddr < ADDR_REGS;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
      wAddr   <= '0;
      wDat    <= '0;
      wStb    <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        wAddr   <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wDat   <= wdata;
        wStb   <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= (wSlot || wAddr <= ADDR_BITDIV) ? RESP_OK : RESP_DEC;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end

  always_comb
  begin
    rdNext = 32'h0;
    rdErr  = 1'b0;
    if (araddr < ADDR_REGS)
      rdNext = {16'h0, mem[araddr[8:2]]};
    else if (araddr == ADDR_FLAGS)
      rdNext = {13'h0, flags};
    else if (araddr == ADDR_IMASK)
      rdNext = {13'h0, intMask};
    else if (araddr == ADDR_SHMASK)
      rdNext = shMask;
    else if (araddr == ADDR_M14)
      rdNext = m14;
    else if (araddr == ADDR_M15)
      rdNext = m15;
    else if (araddr == ADDR_TIMER)
      rdNext = {16'h0, timer};
    else if (araddr == ADDR_BITDIV)
      rdNext = {16'h0, bitDiv};
    else
      rdErr = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OK;
    end
    else if (doRead)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdNext;
      rresp   <= rdErr ? RESP_DEC : RESP_OK;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end

  // Read lock: a pending frame waits rather than tearing a slot being read
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      lockOn   <= 1'b0;
      lockSlot <= '0;
    end
    else if (doRead && araddr < ADDR_REGS && araddr[4:2] == 3'(W_CTRL))
    begin
      lockOn   <= !mem[araddr[8:2]][CODE_LSB+3];
      lockSlot <= araddr[8:5];
    end
    else if (doRead && araddr == ADDR_TIMER)
      lockOn <= 1'b0;

  // Control registers
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      intMask <= '0;
      shMask  <= MASK_RST;
      m14     <= MASK_RST;
      m15     <= MASK_RST;
      bitDiv  <= BIT_LIM_MIN;
    end
    else if (doWrite)
    begin
      if (wAddr == ADDR_IMASK)
        intMask <= FLAG_W'(merge({13'h0, intMask}, wDat, wStb));
      else if (wAddr == ADDR_SHMASK)
        shMask <= merge(shMask, wDat, wStb);
      else if (wAddr == ADDR_M14)
        m14 <= merge(m14, wDat, wStb);
      else if (wAddr == ADDR_M15)
        m15 <= merge(m15, wDat, wStb);
      else if (wAddr == ADDR_BITDIV)
        bitDiv <= 16'(merge({16'h0, bitDiv}, wDat, wStb));
    end

  // Bit-rate divider; never faster than the minimum bit time
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      divCnt  <= '0;
      bitTick <= 1'b0;
    end
    else if (divCnt >= ((bitDiv < BIT_LIM_MIN) ? BIT_LIM_MIN : bitDiv))
    begin
      divCnt  <= '0;
      bitTick <= 1'b1;
    end
    else
    begin
      divCnt  <= divCnt + 16'h1;
      bitTick <= 1'b0;
    end

  // Free-running timer, one count per bit time
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      timer <= '0;
    else if (bitTick)
      timer <= timer + 16'h1;

  // Two serial buffers; the engine only sees rxReady
  assign push = rxValid && rxReady;
  assign pop  = sbValid[sbRd] && !stall;

  always_comb
  begin
    next_sbValid = sbValid;
    if (pop)
      next_sbValid[sbRd] = 1'b0;
    if (push)
      next_sbValid[sbWr] = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      sbValid <= '0;
      sbWr    <= 1'b0;
      sbRd    <= 1'b0;
      rxReady <= 1'b0;
      rxStamp <= '0;
      for (int k = 0; k < 2; k++)
      begin
        sbHi[k]    <= '0;
        sbLo[k]    <= '0;
        sbLen[k]   <= '0;
        sbData[k]  <= '0;
        sbStamp[k] <= '0;
      end
    end
    else
    begin
      if (rxSof)
        rxStamp <= timer;
      if (push)
      begin
        sbHi[sbWr]    <= rxIdHi;
        sbLo[sbWr]    <= rxIdLo;
        sbLen[sbWr]   <= rxLen;
        sbData[sbWr]  <= rxData;
        sbStamp[sbWr] <= rxStamp;
        sbWr          <= !sbWr;
      end
      if (pop)
        sbRd <= !sbRd;
      sbValid <= next_sbValid;
      rxReady <= !next_sbValid[push ? !sbWr : sbWr];
    end

  // One filter per slot; slots 14 and 15 own private masks
  generate
    for (genvar g = 0; g < SLOTS; g++)
    begin : gMatch
      cmb_match uMatch (
        .code    (mem[g*WORDS + W_CTRL][CODE_LSB +: 4]),
        .slotHi  (mem[g*WORDS + W_IDHI]),
        .slotLo  (mem[g*WORDS + W_IDLO]),
        .mask    ((g == 14) ? m14 : ((g == 15) ? m15 : shMask)),
        .frameHi (sbHi[sbRd]),
        .frameLo (sbLo[sbRd]),
        .rxHit   (rxHit[g]),
        .rrHit   (rrHit[g])
      );
    end
  endgenerate

  // Remote responders first, then the lowest-numbered receiver
  always_comb
  begin
    selIdx = '0;
    selRx  = 1'b0;
    selRr  = |rrHit;
    for (int i = SLOTS - 1; i >= 0; i--)
      if (selRr ? rrHit[i] : rxHit[i])
        selIdx = 4'(i);
    selRx = !selRr && |rxHit;
  end

  assign stall    = selRx && lockOn && lockSlot == selIdx;
  assign doStore  = sbValid[sbRd] && selRx && !stall;
  assign doRemote = sbValid[sbRd] && selRr;
  assign txFinish = txSt == TS_BUSY && txDone;

  // Lowest arbitration field among pending transmitters
  always_comb
  begin
    logic [31:0] key;
    logic [31:0] best;
    logic [3:0]  c;
    key    = '0;
    best   = '1;
    c      = '0;
    txCand = 1'b0;
    txBest = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      c   = mem[i*WORDS + W_CTRL][CODE_LSB +: 4];
      key = {mem[i*WORDS + W_IDHI],
             mem[i*WORDS + W_IDHI][HI_IDE] ? mem[i*WORDS + W_IDLO] : 16'h0};
      if ((c == TX_SEND || c == TX_RESP_BUSY) && (!txCand || key < best))
      begin
        txCand = 1'b1;
        txBest = 4'(i);
        best   = key;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      txSt    <= TS_IDLE;
      txValid <= 1'b0;
      txSlot  <= '0;
      txStamp <= '0;
      txIdHi  <= '0;
      txIdLo  <= '0;
      txLen   <= '0;
      txData  <= '0;
    end
    else
      case (txSt)
        TS_IDLE:
          if (txCand)
          begin
            txIdHi  <= mem[{txBest, 3'(W_IDHI)}];
            txIdLo  <= mem[{txBest, 3'(W_IDLO)}];
            txLen   <= mem[{txBest, 3'(W_CTRL)}][3:0];
            txData  <= {mem[{txBest, 3'(W_DATA0)}], mem[{txBest, 3'(W_DATA0 + 1)}],
                        mem[{txBest, 3'(W_DATA0 + 2)}], mem[{txBest, 3'(W_DATA0 + 3)}]};
            txSlot  <= txBest;
            txValid <= 1'b1;
            txSt    <= TS_OFFER;
          end
        TS_OFFER:
          if (txReady)
          begin
            txValid <= 1'b0;
            txStamp <= timer;
            txSt    <= TS_BUSY;
          end
        TS_BUSY:
          if (txDone || txLost)
            txSt <= TS_IDLE;
        default:
          txSt <= TS_IDLE;
      endcase

  // Slot storage: host writes first, device results override
  always_ff @(posedge mclk)
  begin
    if (doWrite && wSlot)
      mem[wAddr[8:2]] <= 16'(merge({16'h0, mem[wAddr[8:2]]}, wDat, wStb));
    if (doStore)
    begin
      mem[{selIdx, 3'(W_CTRL)}] <= {sbStamp[sbRd][15:8],
        (mem[{selIdx, 3'(W_CTRL)}][CODE_LSB +: 4] == RX_EMPTY) ? RX_FULL : RX_OVERRUN,
        sbLen[sbRd]};
      mem[{selIdx, 3'(W_IDHI)}] <= sbHi[sbRd];
      // Standard slots carry the full stamp in the low word
      mem[{selIdx, 3'(W_IDLO)}] <= sbHi[sbRd][HI_IDE] ? sbLo[sbRd] : sbStamp[sbRd];
      for (int d = 0; d < 4; d++)
        mem[{selIdx, 3'(W_DATA0 + d)}] <= sbData[sbRd][63 - d*16 -: 16];
    end
    if (doRemote)
      mem[{selIdx, 3'(W_CTRL)}][CODE_LSB +: 4] <= TX_RESP_BUSY;
    if (txFinish)
    begin
      mem[{txSlot, 3'(W_CTRL)}][15:STAMP_LSB] <= txStamp[15:8];
      if (!txIdHi[HI_IDE])
        mem[{txSlot, 3'(W_IDLO)}] <= txStamp;
      // Remote request turns the slot into a receiver
      if (mem[{txSlot, 3'(W_CTRL)}][CODE_LSB +: 4] == TX_RESP_BUSY)
        mem[{txSlot, 3'(W_CTRL)}][CODE_LSB +: 4] <= TX_RESP;
      else if (txIdHi[HI_IDE] ? txIdLo[LO_RTR] : txIdHi[HI_SRR])
        mem[{txSlot, 3'(W_CTRL)}][CODE_LSB +: 4] <= RX_EMPTY;
      else
        mem[{txSlot, 3'(W_CTRL)}][CODE_LSB +: 4] <= TX_IDLE;
    end
  end

  // Completion flags: hardware set beats a same-cycle write-one clear
  always_comb
  begin
    flagSet = '0;
    flagClr = '0;
    if (doWrite && wAddr == ADDR_FLAGS)
      flagClr = FLAG_W'(merge(32'h0, wDat, wStb));
    if (doStore)
      flagSet[selIdx] = 1'b1;
    if (txFinish)
      flagSet[txSlot] = 1'b1;
    flagSet[EV_BUSOFF] = busOffEvt;
    flagSet[EV_ERR]    = errEvt;
    flagSet[EV_WAKE]   = wakeEvt;
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      flags  <= '0;
      intReq <= 1'b0;
    end
    else
    begin
      flags  <= (flags & ~flagClr) | flagSet;
      intReq <= |(flags & intMask);
    end

  a_store_flag: assert property (
    @(posedge mclk) disable iff (!rst_n) doStore |=> flags[$past(selIdx)])
    else $error("stored frame without completion flag");
  a_lock_block: assert property (
    @(posedge mclk) disable iff (!rst_n)
    lockOn && selRx && lockSlot == selIdx |-> !doStore && !pop)
    else $error("locked slot overwritten");
  a_tx_stamp: assert property (
    @(posedge mclk) disable iff (!rst_n)
    txSt == TS_OFFER && txReady |=> txStamp == $past(timer) && txSt == TS_BUSY)
    else $error("stamp not captured at frame start");
  a_timer_step: assert property (
    @(posedge mclk) disable iff (!rst_n) bitTick |=> timer == $past(timer) + 16'h1)
    else $error("timer did not advance");
  a_tx_flag: assert property (
    @(posedge mclk) disable iff (!rst_n) txFinish |=> flags[$past(txSlot)] && txSt == TS_IDLE)
    else $error("transmit completion lost");
  a_sbuf_full: assert property (
    @(posedge mclk) disable iff (!rst_n) sbValid == 2'b11 |-> !rxReady)
    else $error("frame accepted with both serial buffers full");
  a_resp_code: assert property (
    @(posedge mclk) disable iff (!rst_n)
    doRemote |=> mem[{$past(selIdx), 3'(W_CTRL)}][CODE_LSB +: 4] == TX_RESP_BUSY)
    else $error("remote request not answered");
  a_bit_rate: assert property (
    @(posedge mclk) disable iff (!rst_n) bitTick |=> !bitTick [*8])
    else $error("bit rate above limit");
  a_axi_hold: assert property (
    @(posedge mclk) disable iff (!rst_n) bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
endmodule

// ---- cmb_node_model.sv ----
// Far-side CAN node: supplies received frames and completes offered ones
`timescale 1ns/100ps
module cmb_node_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Frames towards the block
  output logic             rxSof,
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic [15:0]      rxIdHi,
  output logic [15:0]      rxIdLo,
  output logic [3:0]       rxLen,
  output logic [63:0]      rxData,
  // Frames from the block
  input  wire logic        txValid,
  output logic             txReady,
  input  wire logic [15:0] txIdHi,
  input  wire logic [3:0]  txLen,
  input  wire logic [63:0] txData,
  output logic             txDone,
  output logic             txLost
);
  int          lat = 2;
  int          waitCnt;
  logic [15:0] seenHi;
  logic [3:0]  seenLen;
  logic [63:0] seenData;
  assign txLost = 1'b0;
  initial
  begin
    rxSof = 1'b0;
    rxValid = 1'b0;
    {rxIdHi, rxIdLo, rxLen, rxData} = '0;
  end
  // Frame as it came off the wire, handed over once complete
  task automatic send(input logic [15:0] hi, input logic [15:0] lo,
                      input logic [3:0] len, input logic [63:0] d);
    @(posedge mclk);
    rxSof <= 1'b1;
    @(posedge mclk);
    rxSof <= 1'b0;
    {rxIdHi, rxIdLo, rxLen, rxData} <= {hi, lo, len, d};
    rxValid <= 1'b1;
    do @(posedge mclk); while (!rxReady);
    rxValid <= 1'b0;
    // Released lines must not keep showing the old frame
    {rxIdHi, rxIdLo, rxLen, rxData} <= ~{hi, lo, len, d};
  endtask
  // One frame outstanding; completion lat cycles after the take
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      txReady <= 1'b0;
      txDone <= 1'b0;
      waitCnt <= 0;
    end
    else
    begin
      txDone <= waitCnt == 1;
      txReady <= waitCnt == 0 && !(txValid && txReady);
      if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
      else if (txValid && txReady)
      begin
        waitCnt <= lat;
        {seenHi, seenLen, seenData} <= {txIdHi, txLen, txData};
      end
    end
endmodule

// ---- cmb_message_buffers_bench.sv ----
// Self-checking bench for the CAN message-slot block
`timescale 1ns/100ps
module cmb_message_buffers_bench
  import cmb_pkg::*;
;
  logic        mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 0, rready = 1, busOffEvt = 0, errEvt = 0, wakeEvt = 0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf, rxLen, txLen;
  logic        awready, wready, bvalid, arready, rvalid, rxSof, rxValid, rxReady;
  logic        txValid, txReady, txDone, txLost, bitTick, intReq;
  logic [1:0]  bresp, rresp;
  logic [15:0] rxIdHi, rxIdLo, txIdHi, txIdLo;
  logic [63:0] rxData, txData;
  int          err_total = 0, n_checks = 0;

  cmb_message_buffers cmb_message_buffers_inst (.mclk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rxSof, .rxValid, .rxReady, .rxIdHi, .rxIdLo, .rxLen,
    .rxData, .txValid, .txReady, .txIdHi, .txIdLo, .txLen, .txData, .txDone, .txLost,
    .busOffEvt, .errEvt, .wakeEvt, .bitTick, .intReq);
  cmb_node_model cmb_node_model_inst (.mclk, .rst_n, .rxSof, .rxValid, .rxReady, .rxIdHi,
    .rxIdLo, .rxLen, .rxData, .txValid, .txReady, .txIdHi, .txLen, .txData, .txDone, .txLost);

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] sa(input int s, input int w);
    return 10'(s * 32 + w * 4);
  endfunction
  task automatic axW(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // Late bready lets the response wait one cycle
      if (bvalid && !bready) bready <= 1'b1;
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic axR(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  // Poll flags, not the code field, so no slot gets locked
  task automatic waitFlag(input int s);
    logic [1:0]  r;
    logic [31:0] d;
    int          n;
    n = 0;
    do
    begin
      axR(ADDR_FLAGS, d, r);
      n++;
    end
    while (d[s] !== 1'b1 && n < 100);
    chk(d[s], 1'b1);
  endtask
  task automatic t_regs;
    logic [1:0]  r;
    logic [31:0] d, t;
    for (int s = 0; s < SLOTS; s++) axW(sa(s, W_CTRL), 32'h0, r);
    for (int a = 0; a < 3; a++)
    begin
      axR(ADDR_SHMASK + 10'(a * 4), d, r);
      chk(d, MASK_RST);
    end
    axR(ADDR_BITDIV, d, r);
    chk(d, 32'hc7);
    axR(10'h21c, d, r);
    chk(r, RESP_DEC);
    chk(d, 32'h0);
    axW(10'h21c, 32'h1, r);
    chk(r, RESP_DEC);
    axR(ADDR_TIMER, t, r);
    repeat (450) @(posedge mclk);
    axR(ADDR_TIMER, d, r);
    chk(32'(d[15:0] - t[15:0] inside {16'h2, 16'h3}), 32'h1);
    $display("test regs done");
  endtask
  task automatic t_rx;
    logic [1:0]  r;
    logic [31:0] d, c, t;
    axW(ADDR_SHMASK, 32'hffbf_ffff, r);
    axW(sa(0, W_IDHI), 32'h1230, r);
    axW(sa(0, W_CTRL), 32'h0040, r);
    axR(ADDR_TIMER, t, r);
    cmb_node_model_inst.send(16'h1260, 16'h0, 4'h3, 64'ha1b2_c3d4_e5f6_0718);
    waitFlag(0);
    axR(sa(0, W_CTRL), c, r);
    chk(c[7:0], 8'h23);
    axR(sa(0, W_IDHI), d, r);
    chk(d, 32'h1260);
    axR(sa(0, W_DATA0), d, r);
    chk(d, 32'ha1b2);
    // Standard slot: full stamp in the low id word, high byte in control
    axR(sa(0, W_IDLO), d, r);
    chk(32'(d[15:0] - t[15:0] inside {16'h0, 16'h1}), 32'h1);
    chk(d[15:8], c[15:8]);
    axR(ADDR_TIMER, d, r);
    axW(ADDR_FLAGS, 32'h1, r);
    axR(ADDR_FLAGS, d, r);
    chk(d[0], 1'b0);
    $display("test rx done");
  endtask
  task automatic t_tx;
    logic [1:0]  r;
    logic [31:0] d;
    logic [15:0] hi [2];
    logic [3:0]  cd [2];
    hi = '{16'h4000, 16'h4410};
    cd = '{4'h8, 4'h4};
    for (int i = 0; i < 2; i++)
    begin
      cmb_node_model_inst.lat = i ? 40 : 2;
      axW(sa(3, W_IDHI), {16'h0, hi[i]}, r);
      axW(sa(3, W_DATA0), 32'hbeef, r);
      axW(sa(3, W_CTRL), 32'h00c2, r);
      waitFlag(3);
      chk(cmb_node_model_inst.seenHi, hi[i]);
      if (i == 0) chk(cmb_node_model_inst.seenData[63:48], 16'hbeef);
      chk(cmb_node_model_inst.seenLen, 4'h2);
      axR(sa(3, W_CTRL), d, r);
      chk(d[7:4], cd[i]);
      axW(ADDR_FLAGS, 32'h8, r);
    end
    $display("test tx done");
  endtask
  task automatic t_rr;
    logic [1:0]  r;
    logic [31:0] d;
    // A mask-only match must not take a remote frame
    cmb_node_model_inst.send(16'h1230, 16'h0, 4'h0, 64'h0);
    repeat (4) @(posedge mclk);
    axR(ADDR_FLAGS, d, r);
    chk(d[0], 1'b0);
    axW(sa(5, W_IDHI), 32'h1220, r);
    axW(sa(5, W_DATA0), 32'h5500, r);
    axW(sa(5, W_CTRL), 32'h00a1, r);
    cmb_node_model_inst.send(16'h1230, 16'h0, 4'h0, 64'h0);
    waitFlag(5);
    chk(cmb_node_model_inst.seenHi, 16'h1220);
    chk(cmb_node_model_inst.seenLen, 4'h1);
    axR(sa(5, W_CTRL), d, r);
    chk(d[7:4], 4'ha);
    $display("test remote done");
  endtask
  task automatic t_prio;
    logic [1:0]  r;
    logic [31:0] d;
    cmb_node_model_inst.lat = 40;
    axW(sa(8, W_IDHI), 32'h7000, r);
    axW(sa(9, W_IDHI), 32'h6000, r);
    axW(sa(10, W_IDHI), 32'h5000, r);
    // Slot 8 holds the link while 9 and 10 queue behind it
    for (int s = 8; s < 11; s++) axW(sa(s, W_CTRL), 32'h00c0, r);
    waitFlag(10);
    axR(ADDR_FLAGS, d, r);
    chk(d[9], 1'b0);
    waitFlag(9);
    chk(cmb_node_model_inst.seenHi, 16'h6000);
    $display("test priority done");
  endtask
  task automatic t_evt;
    logic [1:0]  r;
    logic [31:0] d;
    axW(ADDR_IMASK, 32'h1_0000, r);
    {busOffEvt, errEvt, wakeEvt} <= 3'b111;
    @(posedge mclk);
    {busOffEvt, errEvt, wakeEvt} <= 3'b000;
    repeat (3) @(posedge mclk);
    chk(intReq, 1'b1);
    axR(ADDR_FLAGS, d, r);
    chk(d[18:16], 3'b111);
    axW(ADDR_FLAGS, 32'h7_0000, r);
    repeat (3) @(posedge mclk);
    chk(intReq, 1'b0);
    $display("test events done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_rr();
    t_prio();
    t_evt();
    final_report();
  end
endmodule
